// File: common/gpp_pkg.sv
// Package with register map, field layout, reset values and modes for the GPIO port block.
package gpp_pkg;
	localparam int         PINS         = 8;
	localparam int         AW           = 4;
	localparam logic [3:0] OFS_DIR      = 4'h0;
	localparam logic [3:0] OFS_LATCH    = 4'h1;
	localparam logic [3:0] OFS_LEVEL    = 4'h2;
	localparam logic [3:0] OFS_IBG      = 4'h3;
	localparam logic [3:0] OFS_PULL     = 4'h4;
	localparam logic [3:0] OFS_OD       = 4'h5;
	localparam logic [3:0] OFS_FUNC     = 4'h6;
	localparam logic [3:0] OFS_PERSEL   = 4'h7;
	localparam logic [3:0] OFS_CFG      = 4'h8;
	localparam logic [7:0] RST_DIR      = 8'h00;
	localparam logic [7:0] RST_LATCH    = 8'h00;
	localparam logic [7:0] RST_IBG      = 8'h00;
	localparam logic [7:0] RST_PULL     = 8'h00;
	localparam logic [7:0] RST_OD       = 8'h00;
	localparam logic [7:0] RST_FUNC     = 8'h00;
	localparam logic [7:0] RST_PERSEL   = 8'h00;
	localparam logic [7:0] RST_CFG      = 8'h00;
	localparam int         CFG_LATCHRB  = 0;
	localparam int         FSEL_LSB     = 0;
	localparam int         FSEL_W       = 3;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	typedef enum logic [1:0] {
		GPP_RB_PIN   = 2'b00,
		GPP_RB_LATCH = 2'b01
	} gpp_rb_mode_t;
endpackage : gpp_pkg

// File: common/gpp_pad_if.sv
// Interface carrying the per-pin pad controls between the register core and the pad stage.
`timescale 1ns/1ps
interface gpp_pad_if #(parameter int PINS = 8);
	logic [PINS-1:0] dir;
	logic [PINS-1:0] latch;
	logic [PINS-1:0] od;
	logic [PINS-1:0] pull;
	logic [PINS-1:0] perip_oe;
	logic [PINS-1:0] perip_out;
	logic [PINS-1:0] pin_out;
	logic [PINS-1:0] pin_oe;
	logic [PINS-1:0] pull_on;

	modport core (output dir, output latch, output od, output pull, output perip_oe,
		output perip_out, input pin_out, input pin_oe, input pull_on);
	modport pad (input dir, input latch, input od, input pull, input perip_oe,
		input perip_out, output pin_out, output pin_oe, output pull_on);
endinterface : gpp_pad_if

// File: design/gpp_pad_drive.sv
// Registered pad drive stage: output value, output enable and pull-up per pin.
`timescale 1ns/1ps
module gpp_pad_drive #(
	parameter int PINS = 8
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	gpp_pad_if.pad    pad
);
	logic [PINS-1:0] drv;
	logic [PINS-1:0] val;

	// A pin drives when software made it an output or a routed peripheral drives it.
	assign drv = pad.dir | pad.perip_oe;
	assign val = (pad.perip_oe & pad.perip_out) | (~pad.perip_oe & pad.latch);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pad.pin_out <= '0;
			pad.pin_oe  <= '0;
		end else begin
			// Open-drain pins keep the line low only, and release it for a one.
			pad.pin_out <= val & ~pad.od;
			pad.pin_oe  <= drv & ~(pad.od & val);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pad.pull_on <= '0;
		end else begin
			pad.pull_on <= pad.pull & ~drv;
		end
	end
endmodule : gpp_pad_drive

// File: design/gpp_in_gate.sv
// Input gating stage: pins reach peripheral inputs only when their buffer is enabled.
`timescale 1ns/1ps
module gpp_in_gate #(
	parameter int PINS = 8
) (
	input  wire logic            mclk_i,
	input  wire logic            rst_i,
	input  wire logic [PINS-1:0] pin_i,
	input  wire logic [PINS-1:0] gate_i,
	input  wire logic [PINS-1:0] idle_i,
	output logic      [PINS-1:0] sample_o,
	output logic      [PINS-1:0] perip_o
);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_o <= '0;
		end else begin
			sample_o <= pin_i;
		end
	end

	// A closed gate gives the peripheral its idle level, so a floating pin is never seen.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			perip_o <= '0;
		end else begin
			perip_o <= (pin_i & gate_i) | (idle_i & ~gate_i);
		end
	end
endmodule : gpp_in_gate

// File: design/gpp_port.sv
// Top of the GPIO port block: register file, function routing and pad control.
//
// Overview of operation
// - A direction bit of one makes the pin an output, zero an input.
// - All direction bits are zero after reset, so pins start as inputs.
// - The direction register reads back the last value written.
// - Reading the output latch returns the latch, never the pin level.
// - The pin level register is read only and returns sampled pins.
// - Optional variant: output pins read their latch through the pin level register.
// - The pull-up is forced off while the pin is an output.
// - Outputs are push-pull; an open-drain bit of one drives low only.
// - A function select register picks which pin carries a routed function.
// - Input buffer enables reset to zero, disconnecting pins from peripherals.
// - Peripheral outputs reach their pin without the input buffer enable.
`timescale 1ns/1ps
module gpp_port #(
	parameter int         PINS       = gpp_pkg::PINS,
	parameter logic [7:0] IDLE_LEVEL = 8'h00
) (
	input  wire logic                   mclk_i,
	input  wire logic                   rst_i,
	input  wire logic [gpp_pkg::AW-1:0] addr_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rdata_o,
	input  wire logic [PINS-1:0]        pin_i,
	output logic      [PINS-1:0]        pin_o,
	output logic      [PINS-1:0]        pin_oe_o,
	output logic      [PINS-1:0]        pullup_o,
	input  wire logic [PINS-1:0]        perip_oe_i,
	input  wire logic [PINS-1:0]        perip_out_i,
	output logic      [PINS-1:0]        perip_in_o,
	output logic                        func_in_o
);
	logic [7:0]      pin_direction_r;
	logic [7:0]      output_latch_r;
	logic [7:0]      input_buffer_gate_r;
	logic [7:0]      pullup_enable_r;
	logic [7:0]      opendrain_select_r;
	logic [7:0]      pin_function_select_r;
	logic [7:0]      perip_sel_r;
	logic [7:0]      cfg_r;
	logic [PINS-1:0] sample;
	logic [PINS-1:0] gated;
	logic [7:0]      level_nxt;
	logic [7:0]      rdata_nxt;
	logic [2:0]      fsel;
	gpp_pkg::gpp_rb_mode_t rb_mode;

	gpp_pad_if #(.PINS(PINS)) pad ();

	function automatic logic wr_hit(input logic [gpp_pkg::AW-1:0] a,
		input logic [gpp_pkg::AW-1:0] ofs, input logic we);
		wr_hit = we && (a == ofs);
	endfunction : wr_hit

	// Direction register; written value is held and read back as is.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_direction_r <= gpp_pkg::RST_DIR;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_DIR, wr_i)) begin
			pin_direction_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			output_latch_r <= gpp_pkg::RST_LATCH;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_LATCH, wr_i)) begin
			output_latch_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			input_buffer_gate_r <= gpp_pkg::RST_IBG;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_IBG, wr_i)) begin
			input_buffer_gate_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pullup_enable_r <= gpp_pkg::RST_PULL;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_PULL, wr_i)) begin
			pullup_enable_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			opendrain_select_r <= gpp_pkg::RST_OD;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_OD, wr_i)) begin
			opendrain_select_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_function_select_r <= gpp_pkg::RST_FUNC;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_FUNC, wr_i)) begin
			pin_function_select_r <= wdata_i;
		end
	end

	// Pins whose output is handed to a peripheral; ANDed with the peripheral's own enable.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			perip_sel_r <= gpp_pkg::RST_PERSEL;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_PERSEL, wr_i)) begin
			perip_sel_r <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= gpp_pkg::RST_CFG;
		end else if (wr_hit(addr_i, gpp_pkg::OFS_CFG, wr_i)) begin
			cfg_r <= wdata_i;
		end
	end

	assign pad.dir       = pin_direction_r[PINS-1:0];
	assign pad.latch     = output_latch_r[PINS-1:0];
	assign pad.od        = opendrain_select_r[PINS-1:0];
	assign pad.pull      = pullup_enable_r[PINS-1:0];
	assign pad.perip_oe  = perip_oe_i & perip_sel_r[PINS-1:0];
	assign pad.perip_out = perip_out_i;

	gpp_pad_drive #(.PINS(PINS)) u_drive (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.pad    (pad.pad)
	);

	assign pin_o    = pad.pin_out;
	assign pin_oe_o = pad.pin_oe;
	assign pullup_o = pad.pull_on;

	gpp_in_gate #(.PINS(PINS)) u_gate (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.pin_i    (pin_i),
		.gate_i   (input_buffer_gate_r[PINS-1:0]),
		.idle_i   (IDLE_LEVEL[PINS-1:0]),
		.sample_o (sample),
		.perip_o  (gated)
	);

	assign perip_in_o = gated;

	// Routed function input taken from the selected pin, after its input gate.
	assign fsel = pin_function_select_r[gpp_pkg::FSEL_LSB +: gpp_pkg::FSEL_W];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			func_in_o <= 1'b0;
		end else begin
			func_in_o <= gated[fsel];
		end
	end

	assign rb_mode = cfg_r[gpp_pkg::CFG_LATCHRB] ? gpp_pkg::GPP_RB_LATCH : gpp_pkg::GPP_RB_PIN;

	always_comb begin
		level_nxt = gpp_pkg::READ_ZERO;
		case (rb_mode)
			gpp_pkg::GPP_RB_LATCH: begin
				level_nxt[PINS-1:0] = (pin_direction_r[PINS-1:0] & output_latch_r[PINS-1:0])
					| (~pin_direction_r[PINS-1:0] & sample);
			end
			default: begin
				level_nxt[PINS-1:0] = sample;
			end
		endcase
	end

	always_comb begin
		case (addr_i)
			gpp_pkg::OFS_DIR:    rdata_nxt = pin_direction_r;
			gpp_pkg::OFS_LATCH:  rdata_nxt = output_latch_r;
			gpp_pkg::OFS_LEVEL:  rdata_nxt = level_nxt;
			gpp_pkg::OFS_IBG:    rdata_nxt = input_buffer_gate_r;
			gpp_pkg::OFS_PULL:   rdata_nxt = pullup_enable_r;
			gpp_pkg::OFS_OD:     rdata_nxt = opendrain_select_r;
			gpp_pkg::OFS_FUNC:   rdata_nxt = pin_function_select_r;
			gpp_pkg::OFS_PERSEL: rdata_nxt = perip_sel_r;
			gpp_pkg::OFS_CFG:    rdata_nxt = cfg_r;
			default:             rdata_nxt = gpp_pkg::READ_ZERO;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe and are zero otherwise.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= gpp_pkg::READ_ZERO;
		end else if (rd_i) begin
			rdata_o <= rdata_nxt;
		end else begin
			rdata_o <= gpp_pkg::READ_ZERO;
		end
	end
endmodule : gpp_port

// File: verif/gpp_board.sv
// Board model driving the pin levels that the port samples.
`timescale 1ns/1ps
module gpp_board (
	input  wire logic       mclk_i,
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pull_i,
	input  wire logic [7:0] ext_i,
	input  wire logic [7:0] ext_en_i,
	output logic      [7:0] lvl_o
);
	logic [7:0] float_r;
	// A floating line toggles so an undriven pin without pull-up can never pass for a steady level.
	always_ff @(posedge mclk_i) begin
		float_r <= (float_r === 8'h55) ? 8'hAA : 8'h55;
		lvl_o   <= (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
			| (~oe_i & ~ext_en_i & (pull_i | float_r));
	end
endmodule : gpp_board

// File: verif/gpp_port_asserts.sv
// Checker for the GPIO port top-level ports.
`timescale 1ns/1ps
module gpp_port_asserts #(
	parameter int         PINS       = 8,
	parameter logic [7:0] IDLE_LEVEL = 8'h00
) (
	input wire logic                   mclk_i,
	input wire logic                   rst_i,
	input wire logic [gpp_pkg::AW-1:0] addr_i,
	input wire logic [7:0]             wdata_i,
	input wire logic                   wr_i,
	input wire logic                   rd_i,
	input wire logic [7:0]             rdata_o,
	input wire logic [PINS-1:0]        pin_oe_o,
	input wire logic [PINS-1:0]        pullup_o,
	input wire logic [PINS-1:0]        perip_oe_i,
	input wire logic [PINS-1:0]        perip_in_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr(a);
		wr_i && addr_i == a;
	endsequence
	sequence s_rd(a);
		rd_i && addr_i == a;
	endsequence
	chk_reset_inputs: assert property ($fell(rst_i) |->
		pin_oe_o == '0 && perip_in_o == IDLE_LEVEL) else $error("bad state after reset");
	chk_dir_readback: assert property ((s_wr(gpp_pkg::OFS_DIR) ##1 !wr_i ##1
		s_rd(gpp_pkg::OFS_DIR)) |=> rdata_o == $past(wdata_i, 3)) else $error("dir readback");
	chk_latch_readback: assert property ((s_wr(gpp_pkg::OFS_LATCH) ##1 !wr_i ##1
		s_rd(gpp_pkg::OFS_LATCH)) |=> rdata_o == $past(wdata_i, 3)) else $error("latch read");
	chk_pull_driven: assert property ((pullup_o & pin_oe_o) == '0)
		else $error("pull-up on driven pin");
	chk_gate_idle: assert property ((s_wr(gpp_pkg::OFS_IBG) and wdata_i == 8'h00)
		##1 !wr_i |=> perip_in_o == IDLE_LEVEL) else $error("gated input not idle");
	chk_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	chk_unmapped_zero: assert property (rd_i && addr_i > gpp_pkg::OFS_CFG |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_input_undriven: assert property ((s_wr(gpp_pkg::OFS_DIR) and wdata_i == 8'h00
		and perip_oe_i == '0) ##1 (!wr_i && perip_oe_i == '0) |=> pin_oe_o == '0)
		else $error("input pin driven");
endmodule : gpp_port_asserts
bind gpp_port gpp_port_asserts #(.PINS(PINS), .IDLE_LEVEL(IDLE_LEVEL)) u_gpp_port_asserts (
	.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_oe_o, .pullup_o,
	.perip_oe_i, .perip_in_o);

// File: verif/test_gpp_port.sv
// Self-checking testbench for the GPIO port block.
`timescale 1ns/1ps
module test_gpp_port;
	logic       mclk_i;
	logic       rst_i;
	logic [3:0] addr_i;
	logic [7:0] wdata_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] rdata_o;
	logic [7:0] pin_i;
	logic [7:0] pin_o;
	logic [7:0] pin_oe_o;
	logic [7:0] pullup_o;
	logic [7:0] perip_oe_i;
	logic [7:0] perip_out_i;
	logic [7:0] perip_in_o;
	logic       func_in_o;
	logic [7:0] ext;
	logic [7:0] ext_en;
	int         err_count;
	int         tests_run;
	gpp_port u_gpp_port (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i,
		.pin_o, .pin_oe_o, .pullup_o, .perip_oe_i, .perip_out_i, .perip_in_o, .func_in_o);
	gpp_board u_gpp_board (.mclk_i, .drv_i(pin_o), .oe_i(pin_oe_o), .pull_i(pullup_o),
		.ext_i(ext), .ext_en_i(ext_en), .lvl_o(pin_i));
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask : chk_rd
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : idle
	task automatic t_reset;
		chk(pin_oe_o, 8'h00);
		chk_rd(gpp_pkg::OFS_DIR, 8'h00);
		chk_rd(gpp_pkg::OFS_IBG, 8'h00);
		chk_rd(4'hF, 8'h00);
		wr(gpp_pkg::OFS_DIR, 8'h5A);
		chk_rd(gpp_pkg::OFS_DIR, 8'h5A);
		chk(pin_oe_o, 8'h5A);
	endtask : t_reset
	task automatic t_latch;
		wr(gpp_pkg::OFS_DIR, 8'h00);
		wr(gpp_pkg::OFS_LATCH, 8'hFF);
		wr(gpp_pkg::OFS_OD, 8'h0F);
		wr(gpp_pkg::OFS_DIR, 8'h0F);
		chk_rd(gpp_pkg::OFS_LATCH, 8'hFF);
		chk(pin_oe_o, 8'h00);
		chk_rd(gpp_pkg::OFS_LEVEL, 8'h50);
		wr(gpp_pkg::OFS_LEVEL, 8'hFF);
		chk_rd(gpp_pkg::OFS_LEVEL, 8'h50);
		wr(gpp_pkg::OFS_CFG, 8'h01);
		chk_rd(gpp_pkg::OFS_LEVEL, 8'h5F);
		wr(gpp_pkg::OFS_LATCH, 8'hF0);
		idle(3);
		chk(pin_oe_o, 8'h0F);
		// Undriven pins still present their latch bit, so only the open-drain lows read zero.
		chk(pin_o, 8'hF0);
	endtask : t_latch
	task automatic t_pull;
		wr(gpp_pkg::OFS_DIR, 8'h00);
		wr(gpp_pkg::OFS_PULL, 8'hFF);
		idle(2);
		chk(pullup_o, 8'hFF);
		wr(gpp_pkg::OFS_DIR, 8'hF0);
		idle(2);
		chk(pullup_o, 8'h0F);
	endtask : t_pull
	task automatic t_gate;
		ext <= 8'hAA;
		wr(gpp_pkg::OFS_DIR, 8'h00);
		wr(gpp_pkg::OFS_IBG, 8'h00);
		idle(3);
		chk(perip_in_o, 8'h00);
		wr(gpp_pkg::OFS_IBG, 8'hFF);
		wr(gpp_pkg::OFS_FUNC, 8'h03);
		idle(3);
		chk(perip_in_o, 8'hAA);
		chk({7'h00, func_in_o}, 8'h01);
		wr(gpp_pkg::OFS_FUNC, 8'h02);
		idle(3);
		chk({7'h00, func_in_o}, 8'h00);
	endtask : t_gate
	task automatic t_perip;
		// Open-drain settings left by earlier scenarios would mask the peripheral; the latch setting would show on the other bits of pin_o.
		wr(gpp_pkg::OFS_IBG, 8'h00);
		wr(gpp_pkg::OFS_OD, 8'h00);
		wr(gpp_pkg::OFS_LATCH, 8'h00);
		wr(gpp_pkg::OFS_PERSEL, 8'h01);
		perip_oe_i <= 8'h01;
		perip_out_i <= 8'h01;
		idle(3);
		chk(pin_oe_o, 8'h01);
		chk(pin_o, 8'h01);
		chk(pullup_o, 8'hFE);
	endtask : t_perip
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		{rst_i, addr_i, wdata_i, wr_i, rd_i} = {1'b1, 4'h0, 8'h00, 1'b0, 1'b0};
		{perip_oe_i, perip_out_i, ext, ext_en} = {8'h00, 8'h00, 8'h50, 8'hFF};
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		idle(1);
		t_reset();
		t_latch();
		t_pull();
		t_gate();
		t_perip();
		tally_and_finish();
	end
endmodule : test_gpp_port
